/* srp_host_model.sv */
`timescale 1ns/1ps
module srp_host_model (
  output logic      chipSelN,
  output logic      serialClk,
  output logic      serial_data_in,
  input  wire logic serialDataOut,
  input  wire logic serialDataOutOe
);
  localparam int HALF = 160;
  // weak pull-up on data out when nobody drives it
  wire sdoWire = (serialDataOutOe === 1'b1) ? serialDataOut : 1'b1;

  initial begin
    chipSelN       = 1'b1;
    serialClk      = 1'b0;
    serial_data_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic shiftByte(input logic [7:0] tx, output logic [7:0] rx, inout bit oeSeen);
    for (int i = 7; i >= 0; i--) begin
      serialClk      = 1'b0;
      serial_data_in = tx[i];
      #(HALF);
      serialClk = 1'b1;
      // sample late in the high phase: device launches a few sys_clk after the fall
      #(HALF - 20);
      rx[i] = sdoWire;
      if (serialDataOutOe === 1'b1) begin
        oeSeen = 1'b1;
      end
      #20;
    end
  endtask

  task automatic xfer(input logic [7:0] cmd, input logic [15:0] addr, input int nData,
                      input logic [31:0] wr, input bit mode3,
                      output logic [31:0] rd, output bit hdrOe);
    logic [7:0] rx;
    bit         dataOe;
    hdrOe     = 1'b0;
    dataOe    = 1'b0;
    rd        = '1;
    serialClk = mode3;
    // pin edges sit 10 ns past a system-clock edge; only the idle clock level set above lands on one
    #(HALF + 10);
    chipSelN = 1'b0;
    #(HALF);
    shiftByte(cmd, rx, hdrOe);
    shiftByte(addr[15:8], rx, hdrOe);
    shiftByte(addr[7:0], rx, hdrOe);
    if (cmd == 8'h0B) begin
      shiftByte(8'h5A, rx, hdrOe);
    end
    for (int k = 0; k < nData; k++) begin
      shiftByte(wr[8*k+:8], rx, dataOe);
      rd[8*k+:8] = rx;
    end
    serialClk = mode3;
    #(HALF);
    chipSelN       = 1'b1;
    // released line: never leave the last bit standing
    serial_data_in = ~serial_data_in;
    #(3*HALF - 10);
  endtask
endmodule

/* srp_pin_sync.sv */
`timescale 1ns/1ps
module srp_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // first stage feeds only the second; nothing else looks at it
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage1[i]  <= 1'h1;
          pinSync[i] <= 1'h1;
        end else if (ce) begin
          stage1[i]  <= pinIn[i];
          pinSync[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

/* srp_pkg.sv */
package srp_pkg;

  localparam int          ADDR_W        = 14;
  localparam int          STEP_MSB      = 15;
  localparam int          STEP_LSB      = 14;
  localparam int          REG_BYTES_MAX = 4;
  localparam int          SYNC_W        = 3;
  localparam int          PIN_CS_N      = 0;
  localparam int          PIN_SCLK      = 1;
  localparam int          PIN_SDI       = 2;

  localparam logic [7:0]  CMD_READ      = 8'h0B;
  localparam logic [7:0]  CMD_WRITE     = 8'h02;

  localparam logic [1:0]  STEP_INC      = 2'h0;
  localparam logic [1:0]  STEP_RSV      = 2'h1;
  localparam logic [1:0]  STEP_DEC      = 2'h2;
  localparam logic [1:0]  STEP_HOLD     = 2'h3;

  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [2:0]  BIT_FIRST     = 3'h0;

  // timing: system clock and the minimum chip-select gap kept by the host
  localparam int          SYS_PERIOD_NS = 40;
  localparam int          CS_GAP_NS     = 50;
  localparam int          CS_GAP_CYC    = (CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int          SCLK_MAX_MHZ  = 25;

  typedef enum logic [9:0] {
    ST_DISABLED = 10'h001,
    ST_ARM      = 10'h002,
    ST_IDLE     = 10'h004,
    ST_CMD      = 10'h008,
    ST_ADDR     = 10'h010,
    ST_FILLER   = 10'h020,
    ST_WDATA    = 10'h040,
    ST_RDATA    = 10'h080,
    ST_HOLDLOW  = 10'h100,
    ST_SKIP     = 10'h200
  } srp_state_t;

  function automatic logic [ADDR_W-1:0] srp_step_addr(input logic [ADDR_W-1:0] a,
                                                     input logic [1:0]        step);
    logic [ADDR_W-1:0] r;
    r = a;
    unique case (step)
      STEP_INC, STEP_RSV: r = ADDR_W'(a + 1'h1);
      STEP_DEC:           r = ADDR_W'(a - 1'h1);
      STEP_HOLD:          r = a;
    endcase
    return r;
  endfunction

endpackage

/* srp_register_port.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module srp_register_port (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire logic                         chipSelN,
  input  wire logic                         serialClk,
  input  wire logic                         serial_data_in,
  output logic                              serialDataOut,
  output logic                              serialDataOutOe,
  input  wire logic                         initDone,
  input  wire logic                         powerAwake,
  input  wire logic                         sleepPermit,
  output logic                              wakeRequest,
  output logic                              stayActive,
  output logic [srp_pkg::ADDR_W-1:0]        regAddr,
  output logic                              regRdReq,
  input  wire logic [7:0]                   regRdData,
  input  wire logic [1:0]                   regWidth,
  output logic                              commitValid,
  output logic [srp_pkg::ADDR_W-1:0]        commitAddr,
  output logic [1:0]                        commitStep,
  output logic [2:0]                        commitBytes,
  output logic [8*srp_pkg::REG_BYTES_MAX-1:0] commitData
);
  import srp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [SYNC_W-1:0] pinSync;
  logic              csNS;
  logic              sclkS;
  logic              sdiS;

  srp_pin_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .pinIn   ({serial_data_in, serialClk, chipSelN}),
    .pinSync (pinSync)
  );

  assign csNS  = pinSync[PIN_CS_N];
  assign sclkS = pinSync[PIN_SCLK];
  assign sdiS  = pinSync[PIN_SDI];

  //////////////////////////////////////////////////////////////////////////////
  // state
  srp_state_t          state;
  srp_state_t          next_state;
  logic                sclkPrev;
  logic                csNPrev;
  logic [2:0]          bitCnt;
  logic [2:0]          next_bitCnt;
  logic [7:0]          rxShift;
  logic [7:0]          next_rxShift;
  logic                cmdRead;
  logic                next_cmdRead;
  logic                addrByte;
  logic                next_addrByte;
  logic [7:0]          addrHi;
  logic [7:0]          next_addrHi;
  logic [ADDR_W-1:0]   addr;
  logic [ADDR_W-1:0]   next_addr;
  logic [1:0]          step;
  logic [1:0]          next_step;
  logic [7:0]          txShift;
  logic [7:0]          next_txShift;
  logic                next_serialDataOut;
  logic                next_serialDataOutOe;
  logic                pendingRead;
  logic                next_pendingRead;
  logic                next_regRdReq;
  logic [8*REG_BYTES_MAX-1:0] wrBuf;
  logic [8*REG_BYTES_MAX-1:0] next_wrBuf;
  logic [1:0]          wrCnt;
  logic [1:0]          next_wrCnt;
  logic [1:0]          wrWidth;
  logic [1:0]          next_wrWidth;
  logic                next_commitValid;
  logic [ADDR_W-1:0]   next_commitAddr;
  logic [1:0]          next_commitStep;
  logic [2:0]          next_commitBytes;
  logic [8*REG_BYTES_MAX-1:0] next_commitData;
  logic                next_wakeRequest;
  logic                next_stayActive;

  logic                csFall;
  logic                csRise;
  logic                riseEv;
  logic                fallEv;
  logic                byteDone;
  logic [7:0]          inByte;
  logic                inFrame;

  // cs and sclk share the synchroniser latency, so their ordering survives
  assign csFall   = csNPrev & ~csNS;
  assign csRise   = ~csNPrev & csNS;
  assign riseEv   = sclkS & ~sclkPrev & ~csNS;
  assign fallEv   = ~sclkS & sclkPrev & ~csNS;
  assign byteDone = riseEv && (bitCnt == BIT_LAST);
  assign inByte   = {rxShift[6:0], sdiS};
  assign inFrame  = state inside {ST_CMD, ST_ADDR, ST_FILLER, ST_WDATA,
                                  ST_RDATA, ST_HOLDLOW, ST_SKIP};
  assign regAddr  = addr;

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic       lastByte;
    logic [8*REG_BYTES_MAX-1:0] newBuf;
    lastByte             = 1'h0;
    newBuf               = wrBuf;
    next_state           = state;
    next_bitCnt          = bitCnt;
    next_rxShift         = rxShift;
    next_cmdRead         = cmdRead;
    next_addrByte        = addrByte;
    next_addrHi          = addrHi;
    next_addr            = addr;
    next_step            = step;
    next_txShift         = txShift;
    next_serialDataOut   = serialDataOut;
    next_serialDataOutOe = serialDataOutOe;
    next_pendingRead     = pendingRead;
    next_regRdReq        = 1'h0;
    next_wrBuf           = wrBuf;
    next_wrCnt           = wrCnt;
    next_wrWidth         = wrWidth;
    next_commitValid     = 1'h0;
    next_commitAddr      = commitAddr;
    next_commitStep      = commitStep;
    next_commitBytes     = commitBytes;
    next_commitData      = commitData;

    if (riseEv && inFrame) begin
      next_rxShift = inByte;
      next_bitCnt  = 3'(bitCnt + 3'h1);
    end

    unique case (state)
      ST_DISABLED: begin
        if (initDone) next_state = ST_ARM;
      end
      ST_ARM: begin
        if (csRise) next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (csFall) begin
          next_bitCnt = BIT_FIRST;
          if (!powerAwake) begin
            next_state           = ST_HOLDLOW;
            next_serialDataOutOe = 1'h1;
            next_serialDataOut   = 1'h0;
          end else begin
            next_state = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (byteDone) begin
          next_addrByte = 1'h0;
          if (inByte == CMD_READ) begin
            next_cmdRead = 1'h1;
            next_state   = ST_ADDR;
          end else if (inByte == CMD_WRITE) begin
            next_cmdRead = 1'h0;
            next_state   = ST_ADDR;
          end else begin
            next_state = ST_SKIP;
          end
        end
      end
      ST_ADDR: begin
        if (byteDone) begin
          if (!addrByte) begin
            next_addrHi   = inByte;
            next_addrByte = 1'h1;
          end else begin
            next_addr  = {addrHi[STEP_LSB-9:0], inByte};
            next_step  = addrHi[STEP_MSB-8:STEP_LSB-8];
            next_wrCnt = 2'h0;
            next_state = cmdRead ? ST_FILLER : ST_WDATA;
          end
        end
      end
      ST_FILLER: begin
        // filler content is shifted in but never looked at
        if (byteDone) begin
          next_state       = ST_RDATA;
          next_pendingRead = 1'h1;
        end
      end
      ST_RDATA: begin
        if (fallEv) begin
          next_serialDataOut   = txShift[7];
          next_serialDataOutOe = 1'h1;
          next_txShift         = {txShift[6:0], 1'h0};
        end
        if (pendingRead) begin
          next_pendingRead = 1'h0;
          next_regRdReq    = 1'h1;
        end
        if (regRdReq) next_txShift = regRdData;
        if (byteDone) begin
          next_addr        = srp_step_addr(addr, step);
          next_pendingRead = 1'h1;
        end
      end
      ST_WDATA: begin
        if (byteDone) begin
          newBuf[{wrCnt, 3'h0} +: 8] = inByte;
          lastByte = ((wrCnt == 2'h0) ? regWidth : wrWidth) == wrCnt;
          next_wrBuf = newBuf;
          if (wrCnt == 2'h0) begin
            next_commitAddr = addr;
            next_commitStep = step;
            next_wrWidth    = regWidth;
          end
          if (lastByte) begin
            next_commitValid = 1'h1;
            next_commitData  = newBuf;
            next_commitBytes = 3'({1'h0, wrCnt} + 3'h1);
            next_wrCnt       = 2'h0;
          end else begin
            next_wrCnt = 2'(wrCnt + 2'h1);
          end
          next_addr = srp_step_addr(addr, step);
        end
      end
      ST_HOLDLOW: begin
        // woken or not, the frame stays ignored until select rises
        next_serialDataOutOe = 1'h1;
        next_serialDataOut   = 1'h0;
      end
      ST_SKIP: begin
      end
    endcase

    // select high ends any frame; a partly gathered write is dropped here
    if (csNS && inFrame) begin
      next_state           = ST_IDLE;
      next_serialDataOutOe = 1'h0;
      next_pendingRead     = 1'h0;
      next_wrCnt           = 2'h0;
    end

    next_wakeRequest = !csNS && !powerAwake &&
                       !(state inside {ST_DISABLED, ST_ARM});
    next_stayActive = stayActive;
    if (sleepPermit) next_stayActive = 1'h0;
    if (csFall && (state == ST_IDLE)) next_stayActive = 1'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state           <= ST_DISABLED;
      sclkPrev        <= 1'h1;
      csNPrev         <= 1'h1;
      bitCnt          <= 3'h0;
      rxShift         <= 8'h00;
      cmdRead         <= 1'h0;
      addrByte        <= 1'h0;
      addrHi          <= 8'h00;
      addr            <= 14'h0000;
      step            <= 2'h0;
      txShift         <= 8'h00;
      serialDataOut   <= 1'h0;
      serialDataOutOe <= 1'h0;
      pendingRead     <= 1'h0;
      regRdReq        <= 1'h0;
      wrBuf           <= 32'h0000_0000;
      wrCnt           <= 2'h0;
      wrWidth         <= 2'h0;
      commitValid     <= 1'h0;
      commitAddr      <= 14'h0000;
      commitStep      <= 2'h0;
      commitBytes     <= 3'h0;
      commitData      <= 32'h0000_0000;
      wakeRequest     <= 1'h0;
      stayActive      <= 1'h0;
    end else if (ce) begin
      state           <= next_state;
      sclkPrev        <= sclkS;
      csNPrev         <= csNS;
      bitCnt          <= next_bitCnt;
      rxShift         <= next_rxShift;
      cmdRead         <= next_cmdRead;
      addrByte        <= next_addrByte;
      addrHi          <= next_addrHi;
      addr            <= next_addr;
      step            <= next_step;
      txShift         <= next_txShift;
      serialDataOut   <= next_serialDataOut;
      serialDataOutOe <= next_serialDataOutOe;
      pendingRead     <= next_pendingRead;
      regRdReq        <= next_regRdReq;
      wrBuf           <= next_wrBuf;
      wrCnt           <= next_wrCnt;
      wrWidth         <= next_wrWidth;
      commitValid     <= next_commitValid;
      commitAddr      <= next_commitAddr;
      commitStep      <= next_commitStep;
      commitBytes     <= next_commitBytes;
      commitData      <= next_commitData;
      wakeRequest     <= next_wakeRequest;
      stayActive      <= next_stayActive;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst || !ce);

  sequence s_filler_done;
    state == ST_FILLER && byteDone && !csNS;
  endsequence

  sequence s_fetch;
    pendingRead ##1 regRdReq;
  endsequence

  AST_CS_HIGH_FLOAT: assert property (csNS && inFrame |=> !serialDataOutOe)
    else $error("data out still driven after select high");

  AST_HEADER_QUIET: assert property (state inside {ST_CMD, ST_ADDR, ST_FILLER}
                                     |-> !serialDataOutOe)
    else $error("data out driven during header bytes");

  AST_HOLD_LOW: assert property (state == ST_HOLDLOW |-> serialDataOutOe && !serialDataOut)
    else $error("data out not held low while waking");

  AST_INIT_QUIET: assert property (state inside {ST_DISABLED, ST_ARM}
                                   |-> !serialDataOutOe && !commitValid && !regRdReq
                                       && !wakeRequest)
    else $error("port active before armed");

  AST_ARM_WAIT: assert property (state == ST_ARM && !csRise |=> state == ST_ARM)
    else $error("left arm state without select rising");

  AST_READ_CODE: assert property (state == ST_CMD && byteDone && inByte == CMD_READ
                                  && !csNS |=> state == ST_ADDR && cmdRead)
    else $error("read command not accepted");

  AST_STEP_DEC: assert property (state inside {ST_WDATA, ST_RDATA} && byteDone && !csNS
                                 && step == STEP_DEC
                                 |=> addr == ADDR_W'($past(addr) - 1'h1))
    else $error("decrement step wrong");

  AST_STEP_RSV: assert property (state inside {ST_WDATA, ST_RDATA} && byteDone && !csNS
                                 && step == STEP_RSV
                                 |=> addr == ADDR_W'($past(addr) + 1'h1))
    else $error("reserved step not treated as increment");

  AST_FIRST_FETCH: assert property (s_filler_done |=> s_fetch)
    else $error("no register fetch after filler byte");

  AST_SNAPSHOT: assert property (regRdReq && state == ST_RDATA && !csNS
                                 |=> txShift == $past(regRdData))
    else $error("read data not snapshotted");

  AST_SHIFT_OUT: assert property (state == ST_RDATA && fallEv && !regRdReq && !csNS
                                  |=> serialDataOutOe && serialDataOut == $past(txShift[7]))
    else $error("read bit not launched on falling edge");

  AST_COMMIT_SRC: assert property (commitValid |-> $past(state == ST_WDATA && byteDone)
                                   && commitBytes == 3'({1'h0, wrWidth} + 3'h1))
    else $error("commit without full register");

  AST_STAY: assert property (stayActive && !sleepPermit |=> stayActive)
    else $error("left communicating state without permit");

endmodule

/* srp_register_port_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module srp_register_port_tb_top;
  import srp_pkg::*;
  logic              sys_clk     = 1'b0;
  logic              rst         = 1'b1;
  logic              initDone    = 1'b0;
  logic              powerAwake  = 1'b1;
  logic              sleepPermit = 1'b0;
  logic              ce          = 1'b1;
  logic [1:0]        regWidth    = 2'h0;
  logic              chipSelN, serialClk, serial_data_in, serialDataOut, serialDataOutOe;
  logic              wakeRequest, stayActive, regRdReq, commitValid;
  logic [ADDR_W-1:0] regAddr, commitAddr, lastAddr;
  logic [1:0]        commitStep, lastStep;
  logic [2:0]        commitBytes, lastBytes;
  logic [31:0]       commitData, lastData, rd;
  logic [7:0]        regRdData;
  int                err_total, check_count, nCommit, nFetch;
  bit                hdrOe;

  function automatic logic [7:0] memByte(input logic [ADDR_W-1:0] a);
    return {a[3:0], ~a[3:0]};
  endfunction

  function automatic logic [ADDR_W-1:0] stepA(input logic [ADDR_W-1:0] a, input logic [1:0] s);
    if (s == 2'h3) return a;
    if (s == 2'h2) return a - 1'b1;
    return a + 1'b1;
  endfunction

  always #20 sys_clk = ~sys_clk;
  assign regRdData = memByte(regAddr);

  always @(posedge sys_clk) begin
    if (commitValid === 1'b1) begin
      nCommit++;
      lastAddr  = commitAddr;
      lastStep  = commitStep;
      lastBytes = commitBytes;
      lastData  = commitData;
    end
    if (regRdReq === 1'b1) begin
      nFetch++;
    end
  end

  srp_register_port dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .chipSelN(chipSelN),
    .serialClk(serialClk), .serial_data_in(serial_data_in), .serialDataOut(serialDataOut),
    .serialDataOutOe(serialDataOutOe), .initDone(initDone), .powerAwake(powerAwake),
    .sleepPermit(sleepPermit), .wakeRequest(wakeRequest), .stayActive(stayActive),
    .regAddr(regAddr), .regRdReq(regRdReq), .regRdData(regRdData), .regWidth(regWidth),
    .commitValid(commitValid), .commitAddr(commitAddr), .commitStep(commitStep),
    .commitBytes(commitBytes), .commitData(commitData));

  srp_host_model host (.chipSelN(chipSelN), .serialClk(serialClk),
    .serial_data_in(serial_data_in), .serialDataOut(serialDataOut),
    .serialDataOutOe(serialDataOutOe));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic testInit;
    host.xfer(CMD_WRITE, 16'h0010, 1, 32'h0000_0077, 1'b0, rd, hdrOe);
    `CHK("write before init", 0, nCommit)
    fork
      host.xfer(CMD_WRITE, 16'h0010, 1, 32'h0000_0077, 1'b1, rd, hdrOe);
      begin
        repeat (40) @(posedge sys_clk);
        initDone <= 1'b1;
      end
    join
    `CHK("write in init frame", 0, nCommit)
    `CHK("drive in init frame", 1'b0, hdrOe)
    // first read access after init, its data checked
    host.xfer(CMD_READ, 16'h0001, 1, '0, 1'b0, rd, hdrOe);
    `CHK("first read", memByte(14'h0001), rd[7:0])
  endtask

  task automatic testReads;
    logic [ADDR_W-1:0] a;
    int                f0;
    for (int s = 0; s < 4; s++) begin
      a = '0;
      f0 = nFetch;
      host.xfer(CMD_READ, {2'(s), a}, 3, '0, s[0], rd, hdrOe);
      `CHK("header drive", 1'b0, hdrOe)
      // one fetch after the filler, then one ahead at the end of every byte
      `CHK("fetch count", f0 + 4, nFetch)
      for (int k = 0; k < 3; k++) begin
        `CHK("read byte", memByte(a), rd[8*k+:8])
        a = stepA(a, 2'(s));
      end
      `CHK("release after select", 1'b0, serialDataOutOe)
    end
  endtask

  task automatic testWrites;
    int n0;
    n0 = nCommit;
    @(posedge sys_clk) regWidth <= 2'h1;
    // third byte is a partial register and must vanish
    host.xfer(CMD_WRITE, {STEP_DEC, 14'h0020}, 3, 32'h0033_2211, 1'b0, rd, hdrOe);
    `CHK("commit count", n0 + 1, nCommit)
    `CHK("commit addr", 14'h0020, lastAddr)
    `CHK("commit bytes", 3'h2, lastBytes)
    `CHK("commit data", 16'h2211, lastData[15:0])
    `CHK("commit step", STEP_DEC, lastStep)
    @(posedge sys_clk) regWidth <= 2'h0;
  endtask

  task automatic testBadCmd;
    int n0;
    n0 = nCommit;
    host.xfer(8'h0A, 16'h0000, 2, 32'h0000_A5A5, 1'b1, rd, hdrOe);
    `CHK("reserved code data", 16'hFFFF, rd[15:0])
    `CHK("reserved code commits", n0, nCommit)
  endtask

  task automatic testWake;
    @(posedge sys_clk) powerAwake <= 1'b0;
    fork
      host.xfer(CMD_READ, 16'h0000, 2, '0, 1'b0, rd, hdrOe);
      begin
        repeat (100) @(posedge sys_clk);
        powerAwake <= 1'b1;
        #1;
        `CHK("wake request", 1'b1, wakeRequest)
      end
    join
    `CHK("held low while waking", 16'h0000, rd[15:0])
    host.xfer(CMD_READ, 16'h0003, 1, '0, 1'b0, rd, hdrOe);
    `CHK("read after wake", memByte(14'h0003), rd[7:0])
    `CHK("stay active", 1'b1, stayActive)
    // a permit while the enable is low must not be seen
    @(posedge sys_clk) ce <= 1'b0;
    @(posedge sys_clk) sleepPermit <= 1'b1;
    @(posedge sys_clk) sleepPermit <= 1'b0;
    @(posedge sys_clk) ce <= 1'b1;
    #1;
    `CHK("frozen by enable", 1'b1, stayActive)
    @(posedge sys_clk) sleepPermit <= 1'b1;
    @(posedge sys_clk) sleepPermit <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("sleep permitted", 1'b0, stayActive)
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    testInit();
    testReads();
    testWrites();
    testBadCmd();
    testWake();
    final_report();
  end
endmodule
